// [design/edge_sync.sv]
// Two-flop synchroniser with edge detection for one pin input.
`timescale 1ns/10ps
module edge_sync #(
    parameter logic RESET_LEVEL = 1'b0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Pin side
    input wire logic pin_in,
    // Synchronised side
    output logic level,
    output logic rise,
    output logic fall
);
    logic meta_q;
    logic meta_d;
    logic sync_q;
    logic sync_d;
    logic prev_q;
    logic prev_d;

    always_comb begin
        meta_d = pin_in;
        sync_d = meta_q;
        prev_d = sync_q;
    end

    // The first flop feeds only the second, so metastability never reaches the edge logic.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_q <= RESET_LEVEL;
            sync_q <= RESET_LEVEL;
            prev_q <= RESET_LEVEL;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            prev_q <= prev_d;
        end
    end

    assign level = sync_q;
    assign rise = sync_q & ~prev_q;
    assign fall = ~sync_q & prev_q;
endmodule : edge_sync

// [design/sar_adc_pkg.sv]
// Package of constants for the serial converter readout block.
package sar_adc_pkg;
    localparam int RESULT_BITS = 12;
    localparam int LEAD_ZEROS = 4;
    localparam int FRAME_BITS = 16;
    localparam int COUNT_W = 5;
    localparam logic [4:0] COUNT_ZERO = 5'h00;
    localparam logic [4:0] COUNT_ONE = 5'h01;
    localparam logic [4:0] COUNT_LAST = 5'h0F;
    localparam logic [11:0] RESULT_RESET = 12'h000;
    typedef enum logic [1:0] {
        ST_POWER_DOWN,
        ST_TRACK,
        ST_CONVERT
    } conv_state_e;
endpackage : sar_adc_pkg

// [design/sar_adc_serial_readout.sv]
// Serial strobe and readout logic of a 12-bit differential converter.
`timescale 1ns/10ps
module sar_adc_serial_readout #(
    parameter int RESULT_BITS = sar_adc_pkg::RESULT_BITS,
    parameter int FRAME_BITS = sar_adc_pkg::FRAME_BITS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Host link pins
    input wire logic conv_strobe_n,
    input wire logic serial_clk,
    output logic serial_result_out,
    output logic serial_result_oe,
    // Analog front end stand-in
    input wire logic [RESULT_BITS-1:0] sample_code,
    output logic powered_up,
    output logic tracking
);
    logic strobe_level;
    logic strobe_rise;
    logic strobe_fall;
    logic sclk_fall;

    edge_sync #(.RESET_LEVEL(1'b1)) u_strobe_sync (
        .clk(clk),
        .reset_n(reset_n),
        .pin_in(conv_strobe_n),
        .level(strobe_level),
        .rise(strobe_rise),
        .fall(strobe_fall)
    );

    edge_sync #(.RESET_LEVEL(1'b0)) u_sclk_sync (
        .clk(clk),
        .reset_n(reset_n),
        .pin_in(serial_clk),
        .level(),
        .rise(),
        .fall(sclk_fall)
    );

    sar_adc_pkg::conv_state_e state_q;
    sar_adc_pkg::conv_state_e state_d;
    logic [sar_adc_pkg::COUNT_W-1:0] count_q;
    logic [sar_adc_pkg::COUNT_W-1:0] count_d;
    logic [RESULT_BITS-1:0] held_q;
    logic [RESULT_BITS-1:0] held_d;
    logic [RESULT_BITS-1:0] result_q;
    logic [RESULT_BITS-1:0] result_d;
    logic out_q;
    logic out_d;
    logic oe_q;
    logic oe_d;

    // Frame position decodes shared by the groups of state below.
    typedef logic [sar_adc_pkg::COUNT_W-1:0] count_t;
    localparam count_t FRAME_END = count_t'(FRAME_BITS);
    localparam count_t LEAD_END = count_t'(sar_adc_pkg::LEAD_ZEROS);
    localparam int IDX_W = $clog2(RESULT_BITS);
    typedef logic [IDX_W-1:0] idx_t;

    logic start_conv;
    logic abort_conv;
    logic frame_step;
    logic frame_done;
    logic in_lead;
    idx_t bit_idx;

    assign start_conv = (state_q == sar_adc_pkg::ST_TRACK) & strobe_rise;
    assign abort_conv = (state_q == sar_adc_pkg::ST_CONVERT) & strobe_fall;
    assign frame_step = (state_q == sar_adc_pkg::ST_CONVERT) & ~strobe_fall & sclk_fall;
    assign frame_done = frame_step & (count_q == FRAME_END);
    assign in_lead = (count_q < LEAD_END);
    assign bit_idx = idx_t'(RESULT_BITS - 1 - (int'(count_q) - sar_adc_pkg::LEAD_ZEROS));

    // The result is resolved one bit per serial clock against the frozen sample, MSB first.
    // Comparing in offset binary keeps the trial order monotonic; the sign bit is restored on output.
    logic [RESULT_BITS-1:0] offset_code;
    logic [RESULT_BITS-1:0] decide;
    assign offset_code = {~held_q[RESULT_BITS-1], held_q[RESULT_BITS-2:0]};
    for (genvar b = 0; b < RESULT_BITS; b++) begin : g_trial
        logic [RESULT_BITS-1:0] trial;
        assign trial = result_q | (RESULT_BITS'(1) << b);
        assign decide[b] = (offset_code >= trial);
    end

    // A strobe fall wins over a coincident serial clock fall, since it ends the frame.
    always_comb begin
        state_d = state_q;
        count_d = count_q;
        case (state_q)
            sar_adc_pkg::ST_POWER_DOWN: begin
                if (strobe_fall) begin
                    state_d = sar_adc_pkg::ST_TRACK;
                end
            end
            sar_adc_pkg::ST_TRACK: begin
                if (start_conv) begin
                    state_d = sar_adc_pkg::ST_CONVERT;
                    count_d = sar_adc_pkg::COUNT_ONE;
                end
            end
            sar_adc_pkg::ST_CONVERT: begin
                if (abort_conv) begin
                    state_d = sar_adc_pkg::ST_TRACK;
                    count_d = sar_adc_pkg::COUNT_ZERO;
                end else if (frame_done) begin
                    state_d = sar_adc_pkg::ST_POWER_DOWN;
                    count_d = sar_adc_pkg::COUNT_ZERO;
                end else if (frame_step) begin
                    count_d = count_q + sar_adc_pkg::COUNT_ONE;
                end
            end
            default: begin
                state_d = sar_adc_pkg::ST_POWER_DOWN;
                count_d = sar_adc_pkg::COUNT_ZERO;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= sar_adc_pkg::ST_POWER_DOWN;
            count_q <= sar_adc_pkg::COUNT_ZERO;
        end else begin
            state_q <= state_d;
            count_q <= count_d;
        end
    end

    // The sample is frozen at the strobe rise, so input movement during a frame cannot reach the code.
    always_comb begin
        held_d = held_q;
        result_d = result_q;
        if (start_conv) begin
            held_d = sample_code;
            result_d = sar_adc_pkg::RESULT_RESET;
        end else if (frame_step && !frame_done && !in_lead) begin
            result_d[bit_idx] = decide[bit_idx];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            held_q <= sar_adc_pkg::RESULT_RESET;
            result_q <= sar_adc_pkg::RESULT_RESET;
        end else begin
            held_q <= held_d;
            result_q <= result_d;
        end
    end

    // The pin is driven low whenever the output is released, so a stale one never lingers behind the enable.
    always_comb begin
        out_d = out_q;
        oe_d = oe_q;
        if (start_conv) begin
            out_d = 1'b0;
            oe_d = 1'b1;
        end else if (abort_conv || frame_done) begin
            out_d = 1'b0;
            oe_d = 1'b0;
        end else if (frame_step) begin
            if (in_lead) begin
                out_d = 1'b0;
            end else if (bit_idx == idx_t'(RESULT_BITS - 1)) begin
                out_d = ~decide[bit_idx];
            end else begin
                out_d = decide[bit_idx];
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            out_q <= 1'b0;
            oe_q <= 1'b0;
        end else begin
            out_q <= out_d;
            oe_q <= oe_d;
        end
    end

    // Status pins are registered from the next state so they move on the same edge as the machine.
    logic powered_q;
    logic powered_d;
    logic tracking_q;
    logic tracking_d;

    always_comb begin
        powered_d = (state_d != sar_adc_pkg::ST_POWER_DOWN);
        tracking_d = (state_d == sar_adc_pkg::ST_TRACK) & ~strobe_level;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            powered_q <= 1'b0;
            tracking_q <= 1'b0;
        end else begin
            powered_q <= powered_d;
            tracking_q <= tracking_d;
        end
    end

    // Every pin below comes straight from a flip-flop.
    assign serial_result_out = out_q;
    assign serial_result_oe = oe_q;
    assign powered_up = powered_q;
    assign tracking = tracking_q;
endmodule : sar_adc_serial_readout

// [dv/host_model.sv]
// Host serial port model.
`timescale 1ns/10ps
module host_model (
    // Clock
    input wire logic clk,
    // Link pins
    output logic conv_strobe_n,
    output logic serial_clk,
    input wire logic serial_result_out,
    input wire logic serial_result_oe
);
    initial conv_strobe_n = 1'b1;
    initial serial_clk = 1'b0;
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_clk
    task automatic strobe_low();
        conv_strobe_n = 1'b0;
        wait_clk(20);
    endtask : strobe_low
    // A released line shows the inverse of its last bit, so stale data cannot pass.
    task automatic read(input int n, output logic [15:0] word);
        word = 16'h0000;
        conv_strobe_n = 1'b1;
        wait_clk(8);
        for (int i = 0; i < n; i++) begin
            serial_clk = 1'b1;
            wait_clk(4);
            word = {word[14:0], serial_result_oe ? serial_result_out : ~word[0]};
            serial_clk = 1'b0;
            wait_clk(4);
        end
    endtask : read
endmodule : host_model

// [dv/sar_adc_chk.sv]
// Assertion checker for the converter readout pins.
`timescale 1ns/10ps
module sar_adc_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Pins and status
    input wire logic conv_strobe_n,
    input wire logic serial_clk,
    input wire logic serial_result_out,
    input wire logic serial_result_oe,
    input wire logic powered_up,
    input wire logic tracking
);
    logic [4:0] sclk_q;
    always_ff @(posedge clk) sclk_q <= {sclk_q[3:0], serial_clk};
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    property p_shift; $changed(serial_result_out) && serial_result_oe |->
        sclk_q[4:3] == 2'h2 || sclk_q[3:2] == 2'h2 || sclk_q[2:1] == 2'h2; endproperty
    a_shift: assert property (p_shift) else $error("data moved off a fall");
    property p_drive; $rose(conv_strobe_n) && tracking |-> ##[2:6] serial_result_oe && !serial_result_out; endproperty
    a_drive: assert property (p_drive) else $error("no drive");
    property p_abort; $fell(conv_strobe_n) && serial_result_oe |-> ##[2:6] !serial_result_oe && tracking; endproperty
    a_abort: assert property (p_abort) else $error("no abort");
    property p_wake; $fell(conv_strobe_n) && !powered_up |-> ##[2:6] powered_up && tracking; endproperty
    a_wake: assert property (p_wake) else $error("no wake");
    property p_rel; $fell(serial_result_oe) |-> !powered_up || tracking; endproperty
    a_rel: assert property (p_rel) else $error("bad release");
    property p_down; !powered_up && conv_strobe_n |=> !powered_up; endproperty
    a_down: assert property (p_down) else $error("woke alone");
    property p_busy; serial_result_oe |-> powered_up && !tracking; endproperty
    a_busy: assert property (p_busy) else $error("bad state");
    property p_lead; $rose(serial_result_oe) |-> !serial_result_out [*8]; endproperty
    a_lead: assert property (p_lead) else $error("no lead zero");
    c_done: cover property ($fell(serial_result_oe) && !powered_up);
    c_abort: cover property ($fell(serial_result_oe) && tracking);
    c_wake: cover property ($rose(powered_up));
endmodule : sar_adc_chk
bind sar_adc_serial_readout sar_adc_chk u_sar_adc_chk (.clk(clk), .reset_n(reset_n), .conv_strobe_n(conv_strobe_n),
    .serial_clk(serial_clk), .serial_result_out(serial_result_out), .serial_result_oe(serial_result_oe),
    .powered_up(powered_up), .tracking(tracking));

// [dv/tb.sv]
// Testbench for the converter readout block.
`timescale 1ns/10ps
module tb;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [11:0] sample_code = 12'h000;
    logic conv_strobe_n, serial_clk, serial_result_out, serial_result_oe, powered_up, tracking;
    logic [15:0] word;
    int errors = 0;
    int checked = 0;
    int cycles = 0;
    always #50 clk = ~clk;
    sar_adc_serial_readout u_sar_adc_serial_readout (.clk(clk), .reset_n(reset_n), .conv_strobe_n(conv_strobe_n),
        .serial_clk(serial_clk), .serial_result_out(serial_result_out), .serial_result_oe(serial_result_oe),
        .sample_code(sample_code), .powered_up(powered_up), .tracking(tracking));
    host_model u_host_model (.clk(clk), .conv_strobe_n(conv_strobe_n), .serial_clk(serial_clk),
        .serial_result_out(serial_result_out), .serial_result_oe(serial_result_oe));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: %h not %h", $time, seen, exp);
        end
    endtask : check
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : print_verdict
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            print_verdict();
        end
    end
    task automatic test_codes();
        logic [11:0] codes [4] = '{12'h7FF, 12'h800, 12'hA5C, 12'h001};
        foreach (codes[i]) begin
            sample_code = codes[i];
            u_host_model.strobe_low();
            check({14'h0000, powered_up, tracking}, 16'h0003);
            u_host_model.read(16, word);
            check(word, {4'h0, codes[i]});
            check({14'h0000, powered_up, serial_result_oe}, 16'h0000);
        end
        $display("codes done");
    endtask : test_codes
    task automatic test_abort();
        sample_code = 12'hC3C;
        u_host_model.strobe_low();
        u_host_model.read(6, word);
        check(word, 16'h0003);
        u_host_model.strobe_low();
        check({14'h0000, serial_result_oe, tracking}, 16'h0001);
        sample_code = 12'h5A5;
        fork
            u_host_model.read(16, word);
            begin
                u_host_model.wait_clk(12);
                sample_code = 12'hFFF;
            end
        join
        check(word, 16'h05A5);
        u_host_model.read(16, word);
        check({14'h0000, powered_up, serial_result_oe}, 16'h0000);
        $display("abort done");
    endtask : test_abort
    initial begin
        repeat (16) @(posedge clk);
        #1 reset_n = 1'b1;
        u_host_model.wait_clk(3);
        test_codes();
        test_abort();
        print_verdict();
    end
endmodule : tb
